/* File: eight_bit_tick_counter_consts.vh */
`ifndef EIGHT_BIT_TICK_COUNTER_CONSTS_VH
`define EIGHT_BIT_TICK_COUNTER_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define IDX_TICK_COUNT      8'h01
`define IDX_CONFIG          8'h02
`define IDX_IRQ_STATUS      8'h03
`define IDX_IRQ_MASK        8'h04
`define IDX_INT_CONTROL     8'h0B

// Word index sits in address bits 9:2
`define ADDR_IDX_HI         9
`define ADDR_IDX_LO         2

// ==========================================================
// Config register fields
// ==========================================================
`define CFG_CLK_SRC         5
`define CFG_EDGE_SEL        4
`define CFG_PSC_TO_WDT      3
`define CFG_PSC_HI          2
`define CFG_PSC_LO          0

// ==========================================================
// Interrupt control fields
// ==========================================================
`define ICR_OVF_IE          5
`define ICR_OVF_FLAG        2

// ==========================================================
// Status and mask layout
// ==========================================================
`define ST_OVF              0
`define ST_WDT              1
`define ST_WIDTH            2

// ==========================================================
// Reset values
// ==========================================================
`define RST_TICK_COUNT      8'h00
`define RST_CONFIG          8'hFF
`define RST_IRQ_MASK        2'h0
`define RST_PSC             8'h00

// ==========================================================
// Timing
// ==========================================================
`define TICK_MAX            8'hFF
`define INHIBIT_CYCLES      2'h2
`define INSTR_DIV_DEF       4
`define HTRANS_NONSEQ_BIT   1
`define HRESP_OKAY          1'b0

`endif

/* File: eight_bit_tick_counter.v */
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
`include "eight_bit_tick_counter_consts.vh"

// Summary of operation
// - Rollover FFh to 00h sets overflow flag
// - Timer mode counts instruction cycles
// - Count write stalls counting two cycles
// - Counter mode counts external pin edges
// - Edge select: clear rising, set falling
// - Overflow request masked by enable bit
// - Flag cleared only by software
// - Counter stopped during sleep
// - Prescaler serves counter or watchdog only
// - Prescaler count hidden from software
// - Eight-bit prescaler, ratio software set
module eight_bit_tick_counter #(
  parameter INSTR_DIV = `INSTR_DIV_DEF  // hclk cycles per instruction
) (
  input  wire        hclk,            // Bus clock, 40 MHz
  input  wire        hresetn,         // Async reset, active low
  input  wire        hsel,            // Slave select
  input  wire [31:0] haddr,           // Byte address
  input  wire [1:0]  htrans,          // Transfer type
  input  wire        hwrite,          // Write when high
  input  wire [2:0]  hsize,           // Transfer size
  input  wire [31:0] hwdata,          // Write data
  input  wire        hready,          // Bus ready in
  output wire        hreadyout,       // Slave ready
  output wire        hresp,           // Always OKAY
  output reg  [31:0] hrdata,          // Read data
  input  wire        ext_count_input, // External count pin
  input  wire        sleep_mode,      // Core asleep
  input  wire        wdt_tick,        // Watchdog base period pulse
  output reg         wdt_timeout,     // Watchdog expiry pulse
  output wire        irq              // Level interrupt
);

  // ========================================================
  // Declarations
  // ========================================================
  // Software-visible state
  reg  [7:0]  tick_count_reg;
  reg  [7:0]  tick_count_next;
  reg  [7:0]  config_reg;
  reg         ovf_irq_en_reg;
  reg  [`ST_WIDTH-1:0] irq_status_reg;
  reg  [`ST_WIDTH-1:0] irq_status_next;
  reg  [`ST_WIDTH-1:0] irq_mask_reg;

  // Prescaler, divider and stall state
  reg  [7:0]  psc_reg;
  reg  [7:0]  psc_next;
  reg  [1:0]  inhibit_reg;
  reg  [7:0]  div_reg;
  reg         pin_prev_reg;
  reg         psc_owner_reg;

  // Bus pipeline
  reg         wr_pend_reg;
  reg  [7:0]  wr_idx_reg;

  // Combinational helpers
  reg  [7:0]  rd_mux;
  reg         ovf_event;
  reg         wdt_event;
  reg         count_step;
  reg         psc_fire;

  // Bus decode
  wire        addr_phase;
  wire [7:0]  addr_idx;
  wire        instr_tick;

  // Configuration taps and count sources
  wire        clk_src_ext;
  wire        edge_falling;
  wire        psc_to_wdt;
  wire [2:0]  psc_sel;
  wire [7:0]  psc_mask_cnt;
  wire [7:0]  psc_mask_wdt;
  wire        pin_rise;
  wire        pin_fall;
  wire        src_event;

  // Register write strobes
  wire        wr_tick;
  wire        wr_cfg;
  wire        wr_stat;
  wire        wr_mask;
  wire        wr_icr;
  wire        ovf_req;

  // ========================================================
  // Bus slave: decode
  // ========================================================
  // Zero wait states; every access completes with OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = `HRESP_OKAY;
  assign addr_phase = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
  assign addr_idx   = haddr[`ADDR_IDX_HI:`ADDR_IDX_LO];

  // Write strobes for the data phase
  assign wr_tick = wr_pend_reg & (wr_idx_reg == `IDX_TICK_COUNT);
  assign wr_cfg  = wr_pend_reg & (wr_idx_reg == `IDX_CONFIG);
  assign wr_stat = wr_pend_reg & (wr_idx_reg == `IDX_IRQ_STATUS);
  assign wr_mask = wr_pend_reg & (wr_idx_reg == `IDX_IRQ_MASK);
  assign wr_icr  = wr_pend_reg & (wr_idx_reg == `IDX_INT_CONTROL);

  // Hold a write address until its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_idx_reg <= addr_idx;
      end
    end
  end

  // Read mux; prescaler count never appears here
  always @* begin
    rd_mux = 8'h00;
    case (addr_idx)
      `IDX_TICK_COUNT:  rd_mux = tick_count_reg;
      `IDX_CONFIG:      rd_mux = config_reg;
      `IDX_IRQ_STATUS:  rd_mux = {6'h00, irq_status_reg};
      `IDX_IRQ_MASK:    rd_mux = {6'h00, irq_mask_reg};
      `IDX_INT_CONTROL: begin
        rd_mux[`ICR_OVF_IE]   = ovf_irq_en_reg;
        rd_mux[`ICR_OVF_FLAG] = irq_status_reg[`ST_OVF];
      end
      default:          rd_mux = 8'h00;
    endcase
  end

  // Read data latched at the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= {24'h000000, rd_mux};
    end
  end

  // ========================================================
  // Instruction cycle divider
  // ========================================================
  // One-cycle enable at the instruction rate
  assign instr_tick = (div_reg == INSTR_DIV[7:0] - 8'h01);

  // Free-running, also in sleep, so the post-write stall still drains
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 8'h00;
    end else if (instr_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ========================================================
  // Configuration
  // ========================================================
  // Field taps of the configuration register
  assign clk_src_ext  = config_reg[`CFG_CLK_SRC];
  assign edge_falling = config_reg[`CFG_EDGE_SEL];
  assign psc_to_wdt   = config_reg[`CFG_PSC_TO_WDT];
  assign psc_sel      = config_reg[`CFG_PSC_HI:`CFG_PSC_LO];

  // Counter ratio 2..256, watchdog ratio 1..128
  assign psc_mask_cnt = ({psc_mask_wdt[6:0], 1'b1});
  assign psc_mask_wdt = (8'h01 << psc_sel) - 8'h01;

  // Control registers written from the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_reg     <= `RST_CONFIG;
      ovf_irq_en_reg <= 1'b0;
      irq_mask_reg   <= `RST_IRQ_MASK;
    end else begin
      if (wr_cfg) begin
        config_reg <= hwdata[7:0];
      end
      if (wr_icr) begin
        ovf_irq_en_reg <= hwdata[`ICR_OVF_IE];
      end
      if (wr_mask) begin
        irq_mask_reg <= hwdata[`ST_WIDTH-1:0];
      end
    end
  end

  // ========================================================
  // Source events
  // ========================================================
  // Previous pin level for edge detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= ext_count_input;
    end
  end

  // Raw edges; the pin is taken as synchronous, so no extra stage
  assign pin_rise = ext_count_input & ~pin_prev_reg;
  assign pin_fall = ~ext_count_input & pin_prev_reg;

  // Pick the source; sleep silences both
  assign src_event = sleep_mode ? 1'b0 :
                     clk_src_ext ?
                       (edge_falling ? pin_fall
                                     : pin_rise) :
                       instr_tick;

  // ========================================================
  // Shared prescaler
  // ========================================================
  // Only one owner at a time; the other bypasses it
  always @* begin
    psc_next  = psc_reg;
    psc_fire  = 1'b0;
    wdt_event = 1'b0;
    if (psc_owner_reg != psc_to_wdt) begin
      psc_next = `RST_PSC;  // Flush on hand-over to avoid a short first period
    end else if (psc_to_wdt) begin
      if (wdt_tick) begin
        psc_next  = psc_reg + 8'h01;
        wdt_event = ((psc_reg & psc_mask_wdt) == psc_mask_wdt);
      end
    end else if (wr_tick) begin
      psc_next = `RST_PSC;
    end else if (src_event & (inhibit_reg == 2'h0)) begin
      psc_next = psc_reg + 8'h01;
      psc_fire = ((psc_reg & psc_mask_cnt) == psc_mask_cnt);
    end
    // Counter owns the prescaler: watchdog sees raw ticks
    if (!psc_to_wdt) begin
      wdt_event = wdt_tick;
    end
  end

  // Prescaler state and the registered expiry pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_reg       <= `RST_PSC;
      psc_owner_reg <= 1'b1;
      wdt_timeout   <= 1'b0;
    end else begin
      psc_reg       <= psc_next;
      psc_owner_reg <= psc_to_wdt;
      wdt_timeout   <= wdt_event;
    end
  end

  // ========================================================
  // Tick counter
  // ========================================================
  // Advance decision: direct or through prescaler
  always @* begin
    count_step = 1'b0;
    if (inhibit_reg == 2'h0) begin
      // Prescaler elsewhere: every source event is a step
      if (psc_to_wdt) begin
        count_step = src_event;
      end else begin
        count_step = psc_fire;
      end
    end
  end

  // Next count; a bus write beats any step in the same cycle
  always @* begin
    tick_count_next = tick_count_reg;
    ovf_event       = 1'b0;
    if (wr_tick) begin
      tick_count_next = hwdata[7:0];
    end else if (count_step) begin
      tick_count_next = tick_count_reg + 8'h01;
      ovf_event       = (tick_count_reg == `TICK_MAX);
    end
  end

  // Post-write stall counted in instruction cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_count_reg <= `RST_TICK_COUNT;
      inhibit_reg    <= 2'h0;
    end else begin
      tick_count_reg <= tick_count_next;
      if (wr_tick) begin
        inhibit_reg <= `INHIBIT_CYCLES;
      end else if (instr_tick & (inhibit_reg != 2'h0)) begin
        inhibit_reg <= inhibit_reg - 2'h1;
      end
    end
  end

  // ========================================================
  // Interrupt status
  // ========================================================
  // Set wins over any clear in the same cycle
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr_stat) begin
      irq_status_next = irq_status_reg & ~hwdata[`ST_WIDTH-1:0];
    end
    // Writing zero to the flag bit also clears it
    if (wr_icr & ~hwdata[`ICR_OVF_FLAG]) begin
      irq_status_next[`ST_OVF] = 1'b0;
    end
    // Software may set the flag, e.g. to test its handler
    if (wr_icr & hwdata[`ICR_OVF_FLAG]) begin
      irq_status_next[`ST_OVF] = 1'b1;
    end
    if (ovf_event) begin
      irq_status_next[`ST_OVF] = 1'b1;
    end
    if (wdt_event & psc_to_wdt) begin
      irq_status_next[`ST_WDT] = 1'b1;
    end else if (wdt_event) begin
      irq_status_next[`ST_WDT] = 1'b1;
    end
  end

  // Sticky status flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= {`ST_WIDTH{1'b0}};
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Overflow needs both its mask bit and its enable
  assign ovf_req = irq_status_reg[`ST_OVF] & irq_mask_reg[`ST_OVF]
                 & ovf_irq_en_reg;
  assign irq = ovf_req
             | (irq_status_reg[`ST_WDT] & irq_mask_reg[`ST_WDT]);

endmodule // eight_bit_tick_counter

/* File: tick_counter_checker.sv */
`timescale 1ns/10ps

// ==========================================================
// Port checks for the tick counter
// ==========================================================
module tick_counter_checker (
  input wire        hclk,            // Clock
  input wire        hresetn,         // Reset, active low
  input wire        hsel,            // Select
  input wire [31:0] haddr,           // Address
  input wire [1:0]  htrans,          // Transfer type
  input wire        hwrite,          // Write
  input wire [2:0]  hsize,           // Size
  input wire [31:0] hwdata,          // Write data
  input wire        hready,          // Ready in
  input wire        hreadyout,       // Ready out
  input wire        hresp,           // Response
  input wire [31:0] hrdata,          // Read data
  input wire        ext_count_input, // Count pin
  input wire        sleep_mode,      // Sleep
  input wire        wdt_tick,        // Watchdog tick
  input wire        wdt_timeout,     // Watchdog expiry
  input wire        irq              // Interrupt
);
  reg wr_dp;  // Write data phase in progress

  // Write data phase tracker, so a falling irq can be tied to software
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr_dp <= 1'b0;
    else
      wr_dp <= hsel & htrans[1] & hready & hwrite;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper set");
  chk_rdata_stands: assert property (!(hsel && htrans[1] && hready && !hwrite)
    |=> $stable(hrdata)) else $error("hrdata moved without read");
  chk_wdt_cause: assert property (wdt_timeout |-> $past(wdt_tick))
    else $error("wdt_timeout without tick");
  chk_irq_sw_clear: assert property ($fell(irq) |-> $past(wr_dp))
    else $error("irq dropped without write");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && !wdt_timeout && hrdata == 32'h0)
    else $error("outputs not quiet after reset");
  chk_sleep_no_irq: assert property (sleep_mode && $past(sleep_mode) && $rose(irq)
    |-> $past(wr_dp) || wdt_timeout || $past(wdt_timeout)) else $error("irq rose in sleep");

  cov_irq_fall: cover property ($fell(irq));
  cov_wdt: cover property (wdt_timeout);
  cov_write_irq: cover property (wr_dp && irq);
endmodule  // tick_counter_checker

bind eight_bit_tick_counter tick_counter_checker chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ext_count_input(ext_count_input), .sleep_mode(sleep_mode),
  .wdt_tick(wdt_tick), .wdt_timeout(wdt_timeout), .irq(irq));

/* File: tb.sv */
`timescale 1ns/10ps
`include "eight_bit_tick_counter_consts.vh"

// ==========================================================
// Testbench
// ==========================================================
module tb;
  logic        hclk, hresetn, hsel, hwrite, ext_count_input, sleep_mode, wdt_tick;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hreadyout, hresp, wdt_timeout, irq;
  wire  [31:0] hrdata;
  int          n_errors, n_compared, n_to;

  eight_bit_tick_counter #(.INSTR_DIV(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_count_input(ext_count_input), .sleep_mode(sleep_mode),
    .wdt_tick(wdt_tick), .wdt_timeout(wdt_timeout), .irq(irq));

  // 40 MHz clock
  always #12.5 hclk = ~hclk;

  // Watchdog expiry pulse counter
  always @(posedge hclk) begin
    if (wdt_timeout === 1'b1)
      n_to <= n_to + 1;
  end

  task end_of_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task rp(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Bounded wait for hready at a rising edge
  task rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_errors++;
        end_of_test;
      end
      @(posedge hclk);
    end
  endtask

  // ==========================================================
  // Bus cycles, register index in, byte address is four times it
  // ==========================================================
  task bw(input logic [7:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
  endtask

  task rc(input string nm, input logic [7:0] i, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    rdy;
    rd = hrdata;
    chk(nm, rd, e);
  endtask

  task pw(input int k);
    repeat (k) begin
      wdt_tick <= 1'b1;
      rp(1);
      wdt_tick <= 1'b0;
      rp(3);
    end
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_reset;
    rc("tick", `IDX_TICK_COUNT, 32'h00);
    rc("config", `IDX_CONFIG, 32'hFF);
    rc("status", `IDX_IRQ_STATUS, 32'h00);
    rc("mask", `IDX_IRQ_MASK, 32'h00);
    rc("icr", `IDX_INT_CONTROL, 32'h00);
    bw(8'h0F, 32'hFF);
    rc("unmapped", 8'h0F, 32'h00);
  endtask

  // Read spacing fixed so the tick phase cancels out
  task t_timer;
    bw(`IDX_CONFIG, 32'h08);
    bw(`IDX_TICK_COUNT, 32'h10);
    rp(20);
    rc("inhibit", `IDX_TICK_COUNT, 32'h13);
    rp(38);
    rc("rate", `IDX_TICK_COUNT, 32'h1D);
  endtask

  task t_ovf;
    bw(`IDX_IRQ_MASK, 32'h01);
    bw(`IDX_TICK_COUNT, 32'hFE);
    rp(40);
    chk("irq masked", irq, 1'b0);
    rc("ovf status", `IDX_IRQ_STATUS, 32'h01);
    rc("ovf flag", `IDX_INT_CONTROL, 32'h04);
    bw(`IDX_INT_CONTROL, 32'h24);
    rp(1);
    chk("irq on", irq, 1'b1);
    rp(100);
    chk("irq sticky", irq, 1'b1);
    bw(`IDX_IRQ_STATUS, 32'h01);
    rp(1);
    chk("irq cleared", irq, 1'b0);
    rc("flag cleared", `IDX_INT_CONTROL, 32'h20);
    bw(`IDX_INT_CONTROL, 32'h24);
    rp(1);
    chk("irq sw set", irq, 1'b1);
    bw(`IDX_INT_CONTROL, 32'h20);
    rp(1);
    chk("irq icr clear", irq, 1'b0);
  endtask

  // Odd toggle count leaves rises and falls unequal
  task t_edge(input logic [31:0] cfg, input int k, input logic [31:0] e);
    bw(`IDX_CONFIG, cfg);
    ext_count_input <= 1'b0;
    bw(`IDX_TICK_COUNT, 32'h00);
    rp(12);
    repeat (k) begin
      ext_count_input <= ~ext_count_input;
      rp(3);
    end
    rc("edges", `IDX_TICK_COUNT, e);
  endtask

  task t_sleep;
    bw(`IDX_CONFIG, 32'h08);
    sleep_mode <= 1'b1;
    bw(`IDX_TICK_COUNT, 32'h40);
    rp(40);
    rc("sleep", `IDX_TICK_COUNT, 32'h40);
    sleep_mode <= 1'b0;
  endtask

  task t_wdt;
    bw(`IDX_IRQ_MASK, 32'h03);
    bw(`IDX_CONFIG, 32'h0A);
    n_to = 0;
    pw(8);
    chk("wdt 1:4", n_to, 32'h2);
    bw(`IDX_CONFIG, 32'h02);
    n_to = 0;
    pw(3);
    chk("wdt unscaled", n_to, 32'h3);
    rc("wdt status", `IDX_IRQ_STATUS, 32'h02);
    chk("wdt irq", irq, 1'b1);
  endtask

  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_count_input = 1'b0;
    sleep_mode = 1'b0;
    wdt_tick = 1'b0;
    n_errors = 0;
    n_compared = 0;
    n_to = 0;
    rp(6);
    hresetn <= 1'b1;
    t_reset;
    t_timer;
    t_ovf;
    t_edge(32'h28, 3, 32'h2);
    t_edge(32'h38, 3, 32'h1);
    t_edge(32'h20, 8, 32'h2);
    t_sleep;
    t_wdt;
    end_of_test;
  end
endmodule  // tb
